// ==== tpi_interworking.sv ====
// TDM circuit emulation pseudowire interworking function.
// Behaviour
// [RULE1] One payload octet per timeslot per frame.
// [RULE2] Jitter depth 1 to 250 ms, 1 ms steps.
// [RULE3] Configured depth within 3 to 32 packet delays; the code only clamps the depth to 1 to 250 ms.
// [RULE4] Structured default depths follow timeslot count.
// [RULE5] Overrun discards excess packets and counts.
// [RULE6] Underrun plays all ones or chosen pattern.
// [RULE7] Operational counters and optional enabled alarm.
// [RULE8] Optional RTP header, timestamps from TDM clock.
// [RULE9] Received RTP header is skipped and ignored.
// [RULE10] First nibble zero unless marking ACH.
// [RULE11] Local fault flag follows attachment circuit fault.
// [RULE12] Remote loss flag follows packet loss state.
// [RULE13] SAToP modifier always 00.
// [RULE14] CESoPSN modifier 00 normal, 10 RDI.
// [RULE15] CESoPSN fragment field always zero.
// [RULE16] Length field is size below 64, else 0.
// [RULE17] Every control word carries sequence number.
// [RULE18] Detect lost, discard unreorderable misordered packets.
// [RULE19] Faulted packet payload replaced by fill.
// [RULE20] Faulted packet signaling replaced by fill.
// [RULE21] Report status up, loss or down; log.
// [RULE22] CAS packs 24 T1 or 16 E1 frames.
// [RULE23] Control word bit layout as specified.
// [RULE24] Sequence increments per packet, wraps 65536.
`timescale 1ns/1ps
`default_nettype none
module tpi_interworking #(
  parameter int BUF_DEPTH = 2048,
  parameter int AW        = 11
) (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // Configuration.
  input  wire logic                 adminUp,
  input  wire logic                 unstructured,
  input  wire logic                 cesMode,
  input  wire logic                 casEn,
  input  wire logic                 isE1,
  input  wire logic                 rtpEn,
  input  wire logic [5:0]           slots,
  input  wire logic [7:0]           framesCfg,
  input  wire logic [7:0]           depthMs,
  input  wire logic                 depthDefault,
  input  wire logic                 useIdlePat,
  input  wire logic [7:0]           idlePat,
  input  wire logic [3:0]           sigPat,
  input  wire logic                 alarmEn,
  input  wire logic                 rdiIn,
  input  wire logic                 achMark,
  // TDM receive side of the attachment circuit.
  input  wire logic                 tdmVal,
  input  wire logic [7:0]           tdmByte,
  input  wire logic                 tdmFault,
  input  wire logic                 frameTick,
  // Packets toward the network.
  output logic                      txSop,
  output tpi_pkg::tpi_cw_s          txCw,
  output logic                      txRtp,
  output logic [31:0]               txTs,
  output logic                      txVal,
  output logic [7:0]                txByte,
  output logic                      txEop,
  // Packets from the network.
  input  wire logic                 rxSop,
  input  wire tpi_pkg::tpi_cw_s     rxCw,
  input  wire logic                 rxVal,
  input  wire logic [7:0]           rxByte,
  // Play-out toward the attachment circuit.
  input  wire logic                 playReq,
  output logic [7:0]                playByte,
  output logic [3:0]                playSig,
  output logic                      playFill,
  // Status and statistics.
  output tpi_pkg::tpi_status_e      status,
  output logic [15:0]               ovrCnt,
  output logic [15:0]               undCnt,
  output logic [15:0]               lostCnt,
  output logic                      alarm,
  output logic [7:0]                effDepth
);
  // ==========================================================
  // Packet geometry
  // Frames per packet are fixed by the line type when CAS is on.
  wire logic [7:0]  framesEff = casEn ? (isE1 ? 8'(tpi_pkg::E1_CAS_FRAMES)
                              : 8'(tpi_pkg::T1_CAS_FRAMES)) : framesCfg; // [RULE22]
  wire logic [13:0] pktOct = 14'(slots * framesEff); // [RULE1]
  wire logic [13:0] hdrOct = rtpEn ? 14'(tpi_pkg::CW_BYTES + tpi_pkg::RTP_BYTES)
                                   : 14'(tpi_pkg::CW_BYTES);
  wire logic [13:0] totOct = 14'(pktOct + hdrOct);
  wire logic [5:0]  lenFld = (totOct < 14'(tpi_pkg::LEN_LIMIT))
                             ? totOct[5:0] : 6'h00; // [RULE16]

  // Default depth by timeslot count, then clamp into range.
  wire logic [7:0] defDepth = (slots <= 6'h01) ? tpi_pkg::DEF_ONE :
                              (slots <= tpi_pkg::SLOTS_FEW) ? tpi_pkg::DEF_FEW :
                              (slots <= tpi_pkg::SLOTS_MID) ? tpi_pkg::DEF_MID :
                              tpi_pkg::DEF_MANY; // [RULE4]
  wire logic [7:0] reqDepth = (depthDefault && !unstructured) ? defDepth
                                                              : depthMs;
  wire logic [7:0] useDepth = (reqDepth < tpi_pkg::DEPTH_MIN) ? tpi_pkg::DEPTH_MIN :
                              (reqDepth > tpi_pkg::DEPTH_MAX) ? tpi_pkg::DEPTH_MAX :
                              reqDepth; // [RULE2]
  // Octet budget of the buffer; a line of N slots gives 8N octets per ms.
  wire logic [21:0] wantOct = 22'(useDepth * tpi_pkg::FRAMES_PER_MS * slots);
  wire logic [AW:0] maxOct  = (wantOct > 22'(BUF_DEPTH)) ? (AW+1)'(BUF_DEPTH)
                                                         : wantOct[AW:0];

  // ==========================================================
  // Transmit control word
  logic        lossQ;
  logic [15:0] seqQ;
  logic [13:0] octQ;
  logic [31:0] tsQ;
  tpi_pkg::tpi_cw_s cwNew;
  wire logic txFirst = tdmVal && (octQ == 14'h0000);
  wire logic txLast  = tdmVal && (octQ == pktOct - 14'h0001);

  // Fields of the word built at the first octet of each packet.
  always_comb
  begin
    cwNew        = '0;
    cwNew.nib    = achMark ? tpi_pkg::ACH_NIB : tpi_pkg::ZERO_NIB; // [RULE10]
    cwNew.lFault = tdmFault; // [RULE11]
    cwNew.rLoss  = lossQ; // [RULE12]
    cwNew.mod    = (cesMode && !tdmFault && rdiIn) ? tpi_pkg::MOD_RDI
                                                   : tpi_pkg::MOD_NORMAL; // [RULE13] [RULE14]
    cwNew.fragment_field    = tpi_pkg::FRG_ZERO; // [RULE15]
    cwNew.len    = lenFld;
    cwNew.seq    = seqQ; // [RULE17] [RULE23]
  end

  // Octet counter, sequence number and recovered-clock timestamp.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      octQ <= 14'h0000;
      seqQ <= 16'h0000;
      tsQ  <= 32'h00000000;
    end
    else
    begin
      if (frameTick)
        tsQ <= tsQ + 32'h00000001; // [RULE8]
      if (txLast)
      begin
        octQ <= 14'h0000;
        seqQ <= seqQ + 16'h0001; // [RULE24]
      end
      else if (tdmVal)
        octQ <= octQ + 14'h0001;
    end
  end

  // Registered packet stream toward the network.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      txSop  <= 1'b0;
      txCw   <= '0;
      txRtp  <= 1'b0;
      txTs   <= 32'h00000000;
      txVal  <= 1'b0;
      txByte <= 8'h00;
      txEop  <= 1'b0;
    end
    else
    begin
      txSop  <= txFirst;
      txVal  <= tdmVal;
      txEop  <= txLast;
      txByte <= tdmByte;
      if (txFirst)
      begin
        txCw  <= cwNew;
        txRtp <= rtpEn; // [RULE8]
        txTs  <= tsQ;
      end
    end
  end

  // ==========================================================
  // Receive sequencing and jitter buffer write
  logic [15:0] expQ;
  logic        seenQ;
  logic        takeQ;
  logic        dropQ;
  logic        faultQ;
  logic [3:0]  skipQ;
  logic [8:0]  mem [BUF_DEPTH];
  logic [AW-1:0] wrQ;
  logic [AW-1:0] rdQ;
  logic [AW:0]   lvlQ;
  logic          playQ;
  wire logic [15:0] seqGap = rxCw.seq - expQ;
  // A packet behind the expected number cannot be reordered any more.
  wire logic ahead  = !seqGap[15];
  wire logic accept = rxSop && (!seenQ || ahead); // [RULE18]
  wire logic rxData = rxVal && takeQ && !dropQ && (skipQ == 4'h0); // [RULE9]
  wire logic full   = (lvlQ >= maxOct);
  wire logic ovrEvt = rxData && full; // [RULE5]
  wire logic wrEn   = rxData && !full;
  wire logic rdEn   = playReq && playQ && (lvlQ != '0);
  wire logic undEvt = playReq && playQ && (lvlQ == '0);
  wire logic startPlay = !playQ && (lvlQ >= (maxOct >> 1));

  // Sequence tracking, RTP skipping and overrun handling per packet.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      expQ    <= 16'h0000;
      seenQ   <= 1'b0;
      takeQ   <= 1'b0;
      dropQ   <= 1'b0;
      faultQ  <= 1'b0;
      skipQ   <= 4'h0;
      lostCnt <= 16'h0000;
    end
    else
    begin
      if (rxSop)
      begin
        takeQ  <= accept;
        dropQ  <= 1'b0;
        faultQ <= rxCw.lFault;
        skipQ  <= rtpEn ? 4'(tpi_pkg::RTP_BYTES) : 4'h0; // [RULE9]
      end
      else if (rxVal && takeQ && skipQ != 4'h0)
        skipQ <= skipQ - 4'h1;
      else if (ovrEvt)
        dropQ <= 1'b1; // [RULE5]
      if (accept)
      begin
        seenQ <= 1'b1;
        expQ  <= rxCw.seq + 16'h0001;
        if (seenQ)
          lostCnt <= lostCnt + seqGap; // [RULE18]
      end
    end
  end

  // Buffer storage keeps the fault flag beside each octet.
  always_ff @(posedge clock)
  begin
    if (wrEn)
      mem[wrQ] <= {faultQ, rxByte};
  end

  // ==========================================================
  // Play-out and fill selection
  wire logic [8:0] rdWord = mem[rdQ];
  wire logic [7:0] fillByte = (!unstructured && useIdlePat) ? idlePat
                                                            : tpi_pkg::ALL_ONES; // [RULE6] [RULE19]
  wire logic [3:0] fillSig  = (casEn && useIdlePat) ? sigPat
                                                    : tpi_pkg::SIG_ONES; // [RULE20]
  wire logic fillNow = !rdEn || rdWord[8];

  // Pointers, level and the play state of the buffer.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wrQ   <= '0;
      rdQ   <= '0;
      lvlQ  <= '0;
      playQ <= 1'b0;
      lossQ <= 1'b0;
    end
    else
    begin
      if (wrEn)
        wrQ <= (wrQ == AW'(BUF_DEPTH - 1)) ? '0 : wrQ + 1'b1;
      if (rdEn)
        rdQ <= (rdQ == AW'(BUF_DEPTH - 1)) ? '0 : rdQ + 1'b1;
      lvlQ <= lvlQ + (AW+1)'(wrEn) - (AW+1)'(rdEn);
      if (undEvt)
      begin
        playQ <= 1'b0;
        lossQ <= 1'b1; // [RULE12]
      end
      else if (startPlay)
      begin
        playQ <= 1'b1;
        lossQ <= 1'b0;
      end
    end
  end

  // Octet presented to the attachment circuit on each request.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      playByte <= tpi_pkg::ALL_ONES;
      playSig  <= tpi_pkg::SIG_ONES;
      playFill <= 1'b0;
    end
    else if (playReq)
    begin
      playByte <= fillNow ? fillByte : rdWord[7:0]; // [RULE6] [RULE19]
      playSig  <= fillNow ? fillSig : tpi_pkg::SIG_ONES; // [RULE20]
      playFill <= fillNow;
    end
  end

  // ==========================================================
  // Statistics, status and alarm
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ovrCnt   <= 16'h0000;
      undCnt   <= 16'h0000;
      alarm    <= 1'b0;
      status   <= tpi_pkg::ST_DOWN;
      effDepth <= tpi_pkg::DEPTH_MIN;
    end
    else
    begin
      if (ovrEvt && !dropQ && adminUp)
        ovrCnt <= ovrCnt + 16'h0001; // [RULE5] [RULE7] [RULE21]
      if (undEvt && adminUp)
        undCnt <= undCnt + 16'h0001; // [RULE7] [RULE21]
      alarm    <= alarmEn && adminUp && ((ovrEvt && !dropQ) || undEvt); // [RULE7]
      status   <= !adminUp ? tpi_pkg::ST_DOWN :
                  lossQ ? tpi_pkg::ST_LOSS : tpi_pkg::ST_UP; // [RULE21]
      effDepth <= useDepth;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_faultPkt;
    txFirst && tdmFault;
  endsequence
  sequence s_flagOut;
    ##1 txSop && txCw.lFault && txCw.mod == tpi_pkg::MOD_NORMAL;
  endsequence

  AST_FAULT_FLAG: assert property (s_faultPkt |-> s_flagOut) // [RULE11]
    else $error("Fault packet lacks local fault flag.");
  AST_SATOP_MOD: assert property (txSop && !$past(cesMode) |->
    txCw.mod == tpi_pkg::MOD_NORMAL) // [RULE13]
    else $error("SAToP modifier not zero.");
  AST_FRG_ZERO: assert property (txSop |-> txCw.fragment_field == tpi_pkg::FRG_ZERO) // [RULE15]
    else $error("Fragment field not zero.");
  AST_NIB: assert property (txFirst && !achMark |=> txCw.nib == 4'h0) // [RULE10]
    else $error("Leading nibble not zero.");
  AST_SEQ_STEP: assert property (txLast |=> // [RULE24]
    seqQ == $past(seqQ) + 16'h0001)
    else $error("Sequence did not step by one.");
  AST_UND_FILL: assert property (undEvt |=> playFill && playByte == $past(fillByte)) // [RULE6]
    else $error("Underrun did not play fill.");
  AST_OVR_CNT: assert property (ovrEvt && !dropQ && adminUp |=>
    ovrCnt == $past(ovrCnt) + 16'h0001 ##1 dropQ || !takeQ || rxSop) // [RULE5]
    else $error("Overrun not counted or packet not dropped.");
  AST_LOSS_R: assert property (undEvt |=> lossQ ##1 status == tpi_pkg::ST_LOSS
    || !adminUp || !lossQ) // [RULE12]
    else $error("Loss state not reported.");
  AST_STALE_DROP: assert property (rxSop && seenQ && seqGap[15] |=> !takeQ) // [RULE18]
    else $error("Stale packet was accepted.");
endmodule
`default_nettype wire

// ==== tpi_pkg.sv ====
// Constants and types of the TDM pseudowire interworking block.
package tpi_pkg;
  // ==========================================================
  // Control word
  localparam logic [3:0] ZERO_NIB   = 4'h0;
  localparam logic [3:0] ACH_NIB    = 4'h1;
  localparam logic [1:0] MOD_NORMAL = 2'h0;
  localparam logic [1:0] MOD_RDI    = 2'h2;
  localparam logic [1:0] FRG_ZERO   = 2'h0;
  localparam int         LEN_LIMIT  = 64;
  localparam int         CW_BYTES   = 4;
  localparam int         RTP_BYTES  = 12;
  // ==========================================================
  // Framing and jitter buffer
  localparam int T1_CAS_FRAMES = 24;
  localparam int E1_CAS_FRAMES = 16;
  localparam int FRAMES_PER_MS = 8;
  localparam logic [7:0] DEPTH_MIN  = 8'h01;
  localparam logic [7:0] DEPTH_MAX  = 8'hFA;
  localparam logic [7:0] DEF_ONE    = 8'h20;
  localparam logic [7:0] DEF_FEW    = 8'h10;
  localparam logic [7:0] DEF_MID    = 8'h08;
  localparam logic [7:0] DEF_MANY   = 8'h05;
  localparam logic [5:0] SLOTS_FEW  = 6'h04;
  localparam logic [5:0] SLOTS_MID  = 6'h0F;
  localparam logic [7:0] ALL_ONES   = 8'hFF;
  localparam logic [3:0] SIG_ONES   = 4'hF;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_UP, ST_LOSS, ST_DOWN} tpi_status_e;
  typedef struct packed {
    logic [15:0] seq;
    logic [5:0]  len;
    logic [1:0]  fragment_field;
    logic [1:0]  mod;
    logic        rLoss;
    logic        lFault;
    logic [3:0]  nib;
  } tpi_cw_s;
endpackage

// ==== tpi_remote_pe.sv ====
// Remote provider-edge model that sends packets to the receive side.
`timescale 1ns/1ps
`default_nettype none
module tpi_remote_pe (
  // Clock.
  input  wire logic        clock,
  // Packets toward the block.
  output logic             rxSop,
  output tpi_pkg::tpi_cw_s rxCw,
  output logic             rxVal,
  output logic [7:0]       rxByte
);
  // Payload octets sent, oldest first, for the play-out checks.
  logic [7:0] sent[$];

  // The lines start idle.
  initial
  begin
    rxSop = 1'b0;
    rxCw = '0;
    rxVal = 1'b0;
    rxByte = 8'h00;
  end

  // Sends a control word, then hdr header octets and n payload octets.
  task automatic send(input logic [15:0] seq, input logic lf,
                      input int n, input int hdr);
    int i;
    logic [7:0] b;
    @(posedge clock);
    rxCw <= '{seq, 6'h00, 2'h0, 2'h0, 1'b0, lf, 4'h0};
    rxSop <= 1'b1;
    @(posedge clock);
    rxSop <= 1'b0;
    for (i = 0; i < n + hdr; i++)
    begin
      b = 8'($urandom);
      rxVal <= 1'b1;
      rxByte <= b;
      if (i >= hdr)
        sent.push_back(b);
      @(posedge clock);
    end
    rxVal <= 1'b0;
    // A released line shows the inverse of its last value.
    rxByte <= ~b;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench of the TDM pseudowire interworking block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================
  // Signals
  logic clock, rstn, adminUp, unstructured, cesMode, casEn, isE1, rtpEn;
  logic depthDefault, useIdlePat, alarmEn, rdiIn, achMark, tdmVal;
  logic tdmFault, frameTick, playReq, rxSop, rxVal, txSop, txRtp;
  logic txVal, txEop, playFill, alarm, pd;
  logic [5:0]  slots;
  logic [7:0]  framesCfg, depthMs, idlePat, tdmByte, txByte, rxByte;
  logic [7:0]  playByte, effDepth;
  logic [3:0]  sigPat, playSig;
  logic [31:0] txTs;
  logic [15:0] ovrCnt, undCnt, lostCnt, seqNo;
  logic [64:0] e;
  logic [13:0] f;
  tpi_pkg::tpi_cw_s     txCw, rxCw;
  tpi_pkg::tpi_status_e status;
  logic [8:0]  txQ[$];
  logic [64:0] cwQ[$];
  logic [13:0] plQ[$];
  int mismatches, nCompared, ticks, alarms, k;
  int dSl[9] = '{1, 2, 4, 5, 15, 16, 2, 2, 2};
  int dCf[9] = '{9, 9, 9, 9, 9, 9, 0, 250, 255};
  int dEx[9] = '{32, 16, 16, 8, 8, 5, 1, 250, 250};

  tpi_interworking #(.BUF_DEPTH(64), .AW(6)) DUT (
    .clock(clock), .rstn(rstn), .adminUp(adminUp),
    .unstructured(unstructured), .cesMode(cesMode), .casEn(casEn),
    .isE1(isE1), .rtpEn(rtpEn), .slots(slots), .framesCfg(framesCfg),
    .depthMs(depthMs), .depthDefault(depthDefault),
    .useIdlePat(useIdlePat), .idlePat(idlePat), .sigPat(sigPat),
    .alarmEn(alarmEn), .rdiIn(rdiIn), .achMark(achMark),
    .tdmVal(tdmVal), .tdmByte(tdmByte), .tdmFault(tdmFault),
    .frameTick(frameTick), .txSop(txSop), .txCw(txCw), .txRtp(txRtp),
    .txTs(txTs), .txVal(txVal), .txByte(txByte), .txEop(txEop),
    .rxSop(rxSop), .rxCw(rxCw), .rxVal(rxVal), .rxByte(rxByte),
    .playReq(playReq), .playByte(playByte), .playSig(playSig),
    .playFill(playFill), .status(status), .ovrCnt(ovrCnt),
    .undCnt(undCnt), .lostCnt(lostCnt), .alarm(alarm),
    .effDepth(effDepth));
  tpi_remote_pe pe (.clock(clock), .rxSop(rxSop), .rxCw(rxCw),
    .rxVal(rxVal), .rxByte(rxByte));

  // ==========================================================
  // Clock, checks and verdict
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #2000000;
    mismatches++;
    give_verdict();
  end

  // Marks the cycle after each play request.
  always @(posedge clock)
    pd <= playReq;

  // Compares each result with the oldest note in its queue.
  always @(negedge clock)
  begin
    if (txSop === 1'b1)
    begin
      e = cwQ.pop_front();
      chk({txCw, txRtp}, e[64:32]);
      if (e[32])
        chk(txTs, e[31:0]);
    end
    if (txVal === 1'b1)
      chk({txEop, txByte}, txQ.pop_front());
    if (pd === 1'b1)
    begin
      f = plQ.pop_front();
      chk({playFill, playByte}, f[8:0]);
      if (f[13])
        chk(playSig, f[12:9]);
    end
    if (alarm === 1'b1)
      alarms++;
  end

  // ==========================================================
  // Drivers
  task automatic tx_pkt(input logic un, ces, cas, e1, rtp, ach, rdi, flt,
                        input int ns, input int fr, input logic rl);
    int n, ln, i;
    logic [7:0] b;
    n = ns * (cas ? (e1 ? tpi_pkg::E1_CAS_FRAMES : tpi_pkg::T1_CAS_FRAMES)
                  : fr);
    ln = tpi_pkg::CW_BYTES + (rtp ? tpi_pkg::RTP_BYTES : 0) + n;
    @(posedge clock);
    {unstructured, cesMode, casEn, isE1} <= {un, ces, cas, e1};
    {rtpEn, achMark, rdiIn, tdmFault} <= {rtp, ach, rdi, flt};
    slots <= 6'(ns);
    framesCfg <= 8'(fr);
    frameTick <= 1'b1;
    ticks++;
    cwQ.push_back({seqNo, 6'(ln < tpi_pkg::LEN_LIMIT ? ln : 0), 2'h0,
                   (ces & rdi & ~flt) ? tpi_pkg::MOD_RDI : tpi_pkg::MOD_NORMAL,
                   rl, flt, ach ? tpi_pkg::ACH_NIB : tpi_pkg::ZERO_NIB,
                   rtp, 32'(ticks)});
    seqNo++;
    @(posedge clock);
    frameTick <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      tdmVal <= 1'b1;
      tdmByte <= b;
      txQ.push_back({i == n - 1, b});
      @(posedge clock);
    end
    tdmVal <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // Requests n octets; a note without fill takes the next sent octet.
  task automatic play(input int n, input logic [13:0] x);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock);
      playReq <= 1'b1;
      plQ.push_back(x[8] ? x : {6'h00, pe.sent.pop_front()});
      @(posedge clock);
      playReq <= 1'b0;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {rstn, adminUp, unstructured, cesMode, casEn, isE1, rtpEn} = '0;
    {depthDefault, useIdlePat, alarmEn, rdiIn, achMark, tdmVal} = '0;
    {tdmFault, frameTick, playReq, tdmByte, idlePat, sigPat} = '0;
    {slots, framesCfg, depthMs, seqNo} = '0;
    void'($urandom(85743));
    adminUp = 1'b1;
    repeat (6) @(posedge clock);
    chk({status, ovrCnt, undCnt, lostCnt}, {tpi_pkg::ST_DOWN, 48'h0});
    chk({playByte, playSig, playFill, alarm, effDepth}, 22'h3FFC01);
    rstn <= 1'b1;
    tx_pkt(1, 0, 0, 0, 0, 1, 1, 0, 2, 4, 0);
    tx_pkt(0, 1, 0, 0, 1, 0, 1, 0, 2, 4, 0);
    tx_pkt(0, 1, 0, 0, 0, 0, 1, 1, 3, 3, 0);
    tx_pkt(0, 1, 1, 1, 0, 0, 0, 0, 1, 9, 0);
    tx_pkt(0, 1, 1, 0, 0, 0, 0, 0, 3, 9, 0);
    tx_pkt(0, 1, 0, 0, 0, 0, 0, 0, 59, 1, 0);
    tx_pkt(0, 1, 0, 0, 0, 0, 0, 0, 60, 1, 0);
    // Default depths by timeslot count, then clamping of the setting.
    for (k = 0; k < 9; k++)
    begin
      @(posedge clock);
      slots <= 6'(dSl[k]);
      depthMs <= 8'(dCf[k]);
      depthDefault <= k < 6;
      repeat (3) @(posedge clock);
      chk(effDepth, dEx[k]);
    end
    // Receive with a 16-octet budget: two slots, one millisecond.
    @(posedge clock);
    {slots, depthMs, depthDefault, casEn} <= {6'h02, 8'h01, 1'b0, 1'b1};
    {useIdlePat, alarmEn, rtpEn} <= 3'h7;
    idlePat <= 8'($urandom);
    sigPat <= 4'($urandom);
    repeat (3) @(posedge clock);
    // Four-octet packets are two frames, so the depth is four delays.
    pe.send(16'h0000, 1'b0, 4, 12);
    pe.send(16'h0001, 1'b0, 4, 12);
    play(8, 14'h0);
    play(1, {5'h00, 1'b1, idlePat});
    repeat (3) @(posedge clock);
    chk({status, undCnt}, {tpi_pkg::ST_LOSS, 16'h1});
    tx_pkt(0, 1, 1, 0, 0, 0, 0, 0, 2, 4, 1);
    pe.send(16'h0004, 1'b1, 4, 0);
    pe.send(16'h0005, 1'b1, 4, 0);
    repeat (3) @(posedge clock);
    chk({status, lostCnt}, {tpi_pkg::ST_UP, 16'h2});
    play(8, {1'b1, sigPat, 1'b1, idlePat});
    pe.send(16'h0001, 1'b0, 4, 0);
    play(1, {5'h00, 1'b1, idlePat});
    pe.send(16'h0006, 1'b0, 20, 0);
    repeat (3) @(posedge clock);
    chk({ovrCnt, undCnt, lostCnt}, 48'h000100020002);
    chk(alarms, 3);
    adminUp <= 1'b0;
    repeat (3) @(posedge clock);
    chk(status, tpi_pkg::ST_DOWN);
    chk(txQ.size() + cwQ.size() + plQ.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
